// File: common/sfr_bank_pkg.sv
// How it works
// - wide write stores low byte only
// - wide read: low byte valid, upper undefined
// - flag set during read-modify-write survives
// - timer, external, watchdog flags are guarded, except the timer2 external flag
// - reset cause shows exactly one bit
// - watchdog control resets E6 or E4
// - unimplemented bits reset zero, writes ignored
// - bus config loads 00000a11 from pin
// - internal code: config A FF, B 00
// - external code: bus ports push-pull
// - compatible status loads vector, flags cleared
// - timer01 control field layout at 410
// - timer2 control at 418, reset 00
// - timer2 mode layout at 419
// - timer01 mode nibbles per timer
// - toggle enables at bits 2 and 0
// - cause bits: watchdog, command, pin
package sfr_bank_pkg;
   localparam logic [10:0] A_COMPAT_STATUS = 11'h402;
   localparam logic [10:0] A_SEGMENT_SELECT = 11'h403;
   localparam logic [10:0] A_TIMER01_CONTROL = 11'h410;
   localparam logic [10:0] A_TIMER01_TOGGLE = 11'h411;
   localparam logic [10:0] A_TIMER2_CONTROL = 11'h418;
   localparam logic [10:0] A_TIMER2_MODE = 11'h419;
   localparam logic [10:0] A_WATCHDOG_CONTROL = 11'h41F;
   localparam logic [10:0] A_SOFT_IRQ_REQUEST = 11'h42A;
   localparam logic [10:0] A_SYSTEM_CONFIG = 11'h440;
   localparam logic [10:0] A_TIMER0_LOW = 11'h450;
   localparam logic [10:0] A_TIMER0_HIGH = 11'h451;
   localparam logic [10:0] A_TIMER1_LOW = 11'h452;
   localparam logic [10:0] A_TIMER1_HIGH = 11'h453;
   localparam logic [10:0] A_TIMER2_LOW = 11'h458;
   localparam logic [10:0] A_TIMER2_HIGH = 11'h459;
   localparam logic [10:0] A_CAPTURE_LOW = 11'h45A;
   localparam logic [10:0] A_CAPTURE_HIGH = 11'h45B;
   localparam logic [10:0] A_TIMER01_MODE = 11'h45C;
   localparam logic [10:0] A_FEED_FIRST = 11'h45D;
   localparam logic [10:0] A_FEED_SECOND = 11'h45E;
   localparam logic [10:0] A_WATCHDOG_RELOAD = 11'h45F;
   localparam logic [10:0] A_RESET_CAUSE = 11'h463;
   localparam logic [10:0] A_UART1_ADDR_MASK = 11'h466;
   localparam logic [10:0] A_BUS_CONFIG = 11'h46A;
   localparam logic [10:0] A_CONFIG_A_BASE = 11'h470;
   localparam logic [10:0] A_CONFIG_B_BASE = 11'h4F0;
   localparam logic [10:0] A_SOFT_IRQ_ENABLE = 11'h47A;
   localparam int NUM_PORTS = 7;
   // implemented-bit masks
   localparam logic [7:0] M_SYSTEM_CONFIG = 8'h0F;
   localparam logic [7:0] M_SOFT_IRQ = 8'h7F;
   localparam logic [7:0] M_TIMER2_MODE = 8'h33;
   localparam logic [7:0] M_TIMER01_TOGGLE = 8'h05;
   localparam logic [7:0] M_WATCHDOG_CONTROL = 8'hE6;
   localparam logic [7:0] M_FULL = 8'hFF;
   // guarded flag masks
   localparam logic [7:0] G_TIMER01_CONTROL = 8'hAA;
   localparam logic [7:0] G_TIMER2_CONTROL = 8'h80;
   localparam logic [7:0] G_WATCHDOG_CONTROL = 8'h02;
   // field positions
   localparam int B_TIMER1_OVERFLOW = 7;
   localparam int B_TIMER0_OVERFLOW = 5;
   localparam int B_EXT1_FLAG = 3;
   localparam int B_EXT0_FLAG = 1;
   localparam int B_TIMER2_OVERFLOW = 7;
   localparam int B_TIMER2_EXTERNAL_FLAG = 6;
   localparam int B_WATCHDOG_TIMEOUT = 1;
   localparam int B_CAUSE_WATCHDOG = 2;
   localparam int B_CAUSE_COMMAND = 1;
   localparam int B_CAUSE_EXTERNAL_PIN = 0;
   localparam int B_BUS_WIDTH = 2;
   // reset and load values
   localparam logic [7:0] R_ZERO = 8'h00;
   localparam logic [7:0] R_WATCHDOG_OTHER = 8'hE4;
   localparam logic [7:0] R_WATCHDOG_DOG = 8'hE6;
   localparam logic [7:0] R_BUS_CONFIG = 8'h03;
   localparam logic [7:0] R_CONFIG_A_QUASI = 8'hFF;
   localparam logic [7:0] R_CONFIG_B_QUASI = 8'h00;
   localparam logic [7:0] R_CONFIG_A_PUSH = 8'hFF;
   localparam logic [7:0] R_CONFIG_B_PUSH = 8'hFF;
   localparam logic [6:0] EXT_BUS_PORTS = 7'h05;
   localparam logic [7:0] COMPAT_KEEP_MASK = 8'hDC;
   // cycles from reset release to the strap load (synchroniser depth)
   localparam logic [1:0] INIT_CYCLES = 2'h2;
endpackage

// File: src/guarded_flag_reg.sv
`timescale 1ns/10ps
`default_nettype none
module guarded_flag_reg #(
   parameter logic [7:0] IMPL_MASK = 8'hFF,
   parameter logic [7:0] GUARD_MASK = 8'h00
) (
   input wire logic i_sys_clk,
   input wire logic i_reset,
   input wire logic i_load,
   input wire logic [7:0] i_load_value,
   input wire logic i_rd_hit,
   input wire logic i_wr_hit,
   input wire logic [7:0] i_wdata,
   input wire logic [7:0] i_hw_set,
   output logic [7:0] o_value
);
   typedef struct packed {
      logic [7:0] value;
      logic [7:0] pending;
      logic armed;
   } guard_t;
   guard_t q;
   guard_t next_q;

   always_comb begin
      next_q = q;
      if (i_load) begin
         next_q.value = i_load_value & IMPL_MASK;
      end else if (i_wr_hit) begin
         // sets of guarded bits seen since the read phase survive the write phase
         next_q.value = (i_wdata & IMPL_MASK) | (q.pending & GUARD_MASK)
            | (i_hw_set & IMPL_MASK);
      end else begin
         next_q.value = q.value | (i_hw_set & IMPL_MASK);
      end
      if (i_rd_hit) begin
         next_q.armed = 1'b1;
         next_q.pending = i_hw_set & GUARD_MASK;
      end else if (i_wr_hit || i_load) begin
         // plain writes with no read before them clear freely
         next_q.armed = 1'b0;
         next_q.pending = 8'h00;
      end else if (q.armed) begin
         next_q.pending = q.pending | (i_hw_set & GUARD_MASK);
      end
   end

   always_ff @(posedge i_sys_clk or posedge i_reset) begin
      if (i_reset) begin
         q <= '0;
      end else begin
         q <= next_q;
      end
   end

   assign o_value = q.value;
endmodule
`default_nettype wire

// File: src/sfr_bus_register_bank.sv
`timescale 1ns/10ps
`default_nettype none
module sfr_bus_register_bank (
   input wire logic i_sys_clk,
   input wire logic i_reset,
   input wire logic [10:0] i_addr,
   input wire logic i_rd_en,
   input wire logic i_wr_en,
   input wire logic i_wide,
   input wire logic [15:0] i_wdata,
   input wire logic i_cause_watchdog,
   input wire logic i_cause_command,
   input wire logic i_cause_external_pin,
   input wire logic [7:0] i_vector_status,
   input wire logic i_bus_width_pin,
   input wire logic i_external_code_select_pin,
   input wire logic i_timer1_overflow,
   input wire logic i_timer0_overflow,
   input wire logic i_ext1_flag,
   input wire logic i_ext0_flag,
   input wire logic i_timer2_overflow,
   input wire logic i_timer2_external_flag,
   input wire logic i_watchdog_timeout_flag,
   output logic [15:0] o_rdata,
   output logic o_rd_valid,
   output logic o_init_done,
   output logic [7:0] o_timer01_control,
   output logic [7:0] o_timer01_toggle_status,
   output logic [7:0] o_timer2_control,
   output logic [7:0] o_timer2_mode,
   output logic [7:0] o_timer01_mode,
   output logic [7:0] o_watchdog_control,
   output logic [7:0] o_watchdog_reload,
   output logic o_watchdog_feed_first,
   output logic o_watchdog_feed_second,
   output logic [7:0] o_segment_select,
   output logic [7:0] o_soft_irq_request,
   output logic [7:0] o_soft_irq_enable,
   output logic [7:0] o_system_config,
   output logic [7:0] o_uart1_addr_mask,
   output logic [2:0] o_reset_cause,
   output logic [7:0] o_bus_config,
   output logic [7:0] o_compat_status,
   output logic [55:0] o_port_config_a,
   output logic [55:0] o_port_config_b
);
   typedef struct packed {
      logic [1:0] init_cnt;
      logic init_done;
      logic [1:0] bus_width_sync;
      logic [1:0] ext_code_sync;
      logic [7:0] segment_select;
      logic [7:0] timer01_toggle;
      logic [7:0] timer2_mode;
      logic [7:0] soft_irq_request;
      logic [7:0] soft_irq_enable;
      logic [7:0] system_config;
      logic [7:0] timer01_mode;
      logic [7:0] watchdog_reload;
      logic [7:0] uart1_addr_mask;
      logic [7:0][7:0] counts;
      logic [2:0] reset_cause;
      logic [7:0] bus_config;
      logic [7:0] compat_status;
      logic [6:0][7:0] cfg_a;
      logic [6:0][7:0] cfg_b;
      logic [15:0] rdata;
      logic rd_valid;
      logic feed_first;
      logic feed_second;
   } state_t;
   state_t q;
   state_t next_q;

   logic [7:0] wbyte;
   logic init_load;
   logic [7:0] wd_load;
   logic rd_t01_ctl, wr_t01_ctl, rd_t2_ctl, wr_t2_ctl, rd_wd_ctl, wr_wd_ctl;
   logic [7:0] t01_ctl_set, t2_ctl_set, wd_ctl_set;
   logic [7:0] t01_ctl_q, t2_ctl_q, wd_ctl_q;
   logic [7:0] rd_byte;
   logic [2:0] port_idx;
   logic cfg_a_hit, cfg_b_hit;
   logic [3:0] count_idx;

   // the port is a byte: the upper write byte is dropped
   assign wbyte = i_wdata[7:0];
   assign init_load = !q.init_done && (q.init_cnt == sfr_bank_pkg::INIT_CYCLES);
   assign wd_load = i_cause_watchdog ? sfr_bank_pkg::R_WATCHDOG_DOG
                                     : sfr_bank_pkg::R_WATCHDOG_OTHER;
   assign rd_t01_ctl = i_rd_en && (i_addr == sfr_bank_pkg::A_TIMER01_CONTROL);
   assign wr_t01_ctl = i_wr_en && (i_addr == sfr_bank_pkg::A_TIMER01_CONTROL);
   assign rd_t2_ctl = i_rd_en && (i_addr == sfr_bank_pkg::A_TIMER2_CONTROL);
   assign wr_t2_ctl = i_wr_en && (i_addr == sfr_bank_pkg::A_TIMER2_CONTROL);
   assign rd_wd_ctl = i_rd_en && (i_addr == sfr_bank_pkg::A_WATCHDOG_CONTROL);
   assign wr_wd_ctl = i_wr_en && (i_addr == sfr_bank_pkg::A_WATCHDOG_CONTROL);
   assign port_idx = i_addr[2:0];
   assign cfg_a_hit = (i_addr[10:3] == sfr_bank_pkg::A_CONFIG_A_BASE[10:3])
                      && (port_idx != 3'h7);
   assign cfg_b_hit = (i_addr[10:3] == sfr_bank_pkg::A_CONFIG_B_BASE[10:3])
                      && (port_idx != 3'h7);

   always_comb begin
      t01_ctl_set = 8'h00;
      t01_ctl_set[sfr_bank_pkg::B_TIMER1_OVERFLOW] = i_timer1_overflow;
      t01_ctl_set[sfr_bank_pkg::B_TIMER0_OVERFLOW] = i_timer0_overflow;
      t01_ctl_set[sfr_bank_pkg::B_EXT1_FLAG] = i_ext1_flag;
      t01_ctl_set[sfr_bank_pkg::B_EXT0_FLAG] = i_ext0_flag;
      t2_ctl_set = 8'h00;
      t2_ctl_set[sfr_bank_pkg::B_TIMER2_OVERFLOW] = i_timer2_overflow;
      t2_ctl_set[sfr_bank_pkg::B_TIMER2_EXTERNAL_FLAG] = i_timer2_external_flag;
      wd_ctl_set = 8'h00;
      wd_ctl_set[sfr_bank_pkg::B_WATCHDOG_TIMEOUT] = i_watchdog_timeout_flag;
   end

   // guarded flags live in these three; all other registers are plain fields of the state struct
   guarded_flag_reg #(
      .IMPL_MASK(sfr_bank_pkg::M_FULL),
      .GUARD_MASK(sfr_bank_pkg::G_TIMER01_CONTROL)
   ) u_t01_ctl (
      .i_sys_clk(i_sys_clk),
      .i_reset(i_reset),
      .i_load(1'b0),
      .i_load_value(sfr_bank_pkg::R_ZERO),
      .i_rd_hit(rd_t01_ctl),
      .i_wr_hit(wr_t01_ctl),
      .i_wdata(wbyte),
      .i_hw_set(t01_ctl_set),
      .o_value(t01_ctl_q)
   );
   guarded_flag_reg #(
      .IMPL_MASK(sfr_bank_pkg::M_FULL),
      .GUARD_MASK(sfr_bank_pkg::G_TIMER2_CONTROL)
   ) u_t2_ctl (
      .i_sys_clk(i_sys_clk),
      .i_reset(i_reset),
      .i_load(1'b0),
      .i_load_value(sfr_bank_pkg::R_ZERO),
      .i_rd_hit(rd_t2_ctl),
      .i_wr_hit(wr_t2_ctl),
      .i_wdata(wbyte),
      .i_hw_set(t2_ctl_set),
      .o_value(t2_ctl_q)
   );
   // async reset gives zero; the cause-dependent value lands at init
   guarded_flag_reg #(
      .IMPL_MASK(sfr_bank_pkg::M_WATCHDOG_CONTROL),
      .GUARD_MASK(sfr_bank_pkg::G_WATCHDOG_CONTROL)
   ) u_wd_ctl (
      .i_sys_clk(i_sys_clk),
      .i_reset(i_reset),
      .i_load(init_load),
      .i_load_value(wd_load),
      .i_rd_hit(rd_wd_ctl),
      .i_wr_hit(wr_wd_ctl),
      .i_wdata(wbyte),
      .i_hw_set(wd_ctl_set),
      .o_value(wd_ctl_q)
   );

   // timer count bytes: 450-453 then 458-45B
   always_comb begin
      count_idx = 4'hF;
      unique case (i_addr)
         sfr_bank_pkg::A_TIMER0_LOW: count_idx = 4'h0;
         sfr_bank_pkg::A_TIMER0_HIGH: count_idx = 4'h1;
         sfr_bank_pkg::A_TIMER1_LOW: count_idx = 4'h2;
         sfr_bank_pkg::A_TIMER1_HIGH: count_idx = 4'h3;
         sfr_bank_pkg::A_TIMER2_LOW: count_idx = 4'h4;
         sfr_bank_pkg::A_TIMER2_HIGH: count_idx = 4'h5;
         sfr_bank_pkg::A_CAPTURE_LOW: count_idx = 4'h6;
         sfr_bank_pkg::A_CAPTURE_HIGH: count_idx = 4'h7;
         default: count_idx = 4'hF;
      endcase
   end

   // unimplemented bits read zero: one legal value of "unknown"
   always_comb begin
      rd_byte = 8'h00;
      if (cfg_a_hit) begin
         rd_byte = q.cfg_a[port_idx];
      end else if (cfg_b_hit) begin
         rd_byte = q.cfg_b[port_idx];
      end else if (!count_idx[3]) begin
         rd_byte = q.counts[count_idx[2:0]];
      end else begin
         unique case (i_addr)
            sfr_bank_pkg::A_COMPAT_STATUS: rd_byte = q.compat_status;
            sfr_bank_pkg::A_SEGMENT_SELECT: rd_byte = q.segment_select;
            sfr_bank_pkg::A_TIMER01_CONTROL: rd_byte = t01_ctl_q;
            sfr_bank_pkg::A_TIMER01_TOGGLE: rd_byte = q.timer01_toggle;
            sfr_bank_pkg::A_TIMER2_CONTROL: rd_byte = t2_ctl_q;
            sfr_bank_pkg::A_TIMER2_MODE: rd_byte = q.timer2_mode;
            sfr_bank_pkg::A_WATCHDOG_CONTROL: rd_byte = wd_ctl_q;
            sfr_bank_pkg::A_SOFT_IRQ_REQUEST: rd_byte = q.soft_irq_request;
            sfr_bank_pkg::A_SYSTEM_CONFIG: rd_byte = q.system_config;
            sfr_bank_pkg::A_TIMER01_MODE: rd_byte = q.timer01_mode;
            sfr_bank_pkg::A_WATCHDOG_RELOAD: rd_byte = q.watchdog_reload;
            sfr_bank_pkg::A_RESET_CAUSE: rd_byte = {5'h00, q.reset_cause};
            sfr_bank_pkg::A_UART1_ADDR_MASK: rd_byte = q.uart1_addr_mask;
            sfr_bank_pkg::A_BUS_CONFIG: rd_byte = q.bus_config;
            sfr_bank_pkg::A_SOFT_IRQ_ENABLE: rd_byte = q.soft_irq_enable;
            default: rd_byte = 8'h00;
         endcase
      end
   end

   always_comb begin
      next_q = q;
      next_q.bus_width_sync = {q.bus_width_sync[0], i_bus_width_pin};
      next_q.ext_code_sync = {q.ext_code_sync[0], i_external_code_select_pin};
      next_q.feed_first = 1'b0;
      next_q.feed_second = 1'b0;
      next_q.rd_valid = i_rd_en;
      if (i_rd_en) begin
         next_q.rdata = {8'h00, rd_byte};
      end
      if (i_wr_en) begin
         if (cfg_a_hit) begin
            next_q.cfg_a[port_idx] = wbyte;
         end
         if (cfg_b_hit) begin
            next_q.cfg_b[port_idx] = wbyte;
         end
         if (!count_idx[3]) begin
            next_q.counts[count_idx[2:0]] = wbyte;
         end
         unique case (i_addr)
            sfr_bank_pkg::A_COMPAT_STATUS: next_q.compat_status = wbyte;
            sfr_bank_pkg::A_SEGMENT_SELECT: next_q.segment_select = wbyte;
            sfr_bank_pkg::A_TIMER01_TOGGLE:
               next_q.timer01_toggle = wbyte & sfr_bank_pkg::M_TIMER01_TOGGLE;
            sfr_bank_pkg::A_TIMER2_MODE:
               next_q.timer2_mode = wbyte & sfr_bank_pkg::M_TIMER2_MODE;
            sfr_bank_pkg::A_SOFT_IRQ_REQUEST:
               next_q.soft_irq_request = wbyte & sfr_bank_pkg::M_SOFT_IRQ;
            sfr_bank_pkg::A_SYSTEM_CONFIG:
               next_q.system_config = wbyte & sfr_bank_pkg::M_SYSTEM_CONFIG;
            sfr_bank_pkg::A_TIMER01_MODE: next_q.timer01_mode = wbyte;
            sfr_bank_pkg::A_WATCHDOG_RELOAD: next_q.watchdog_reload = wbyte;
            sfr_bank_pkg::A_FEED_FIRST: next_q.feed_first = 1'b1;
            sfr_bank_pkg::A_FEED_SECOND: next_q.feed_second = 1'b1;
            sfr_bank_pkg::A_UART1_ADDR_MASK: next_q.uart1_addr_mask = wbyte;
            sfr_bank_pkg::A_BUS_CONFIG: next_q.bus_config = wbyte;
            sfr_bank_pkg::A_SOFT_IRQ_ENABLE:
               next_q.soft_irq_enable = wbyte & sfr_bank_pkg::M_SOFT_IRQ;
            default: next_q.segment_select = next_q.segment_select;
         endcase
      end
      // straps are read only after two sync stages have settled
      if (!q.init_done) begin
         next_q.init_cnt = q.init_cnt + 2'h1;
      end
      if (init_load) begin
         next_q.init_done = 1'b1;
         // priority keeps the cause one-hot even if several are raised
         next_q.reset_cause = 3'h0;
         if (i_cause_watchdog) begin
            next_q.reset_cause[sfr_bank_pkg::B_CAUSE_WATCHDOG] = 1'b1;
         end else if (i_cause_command) begin
            next_q.reset_cause[sfr_bank_pkg::B_CAUSE_COMMAND] = 1'b1;
         end else begin
            next_q.reset_cause[sfr_bank_pkg::B_CAUSE_EXTERNAL_PIN] = 1'b1;
         end
         next_q.bus_config = sfr_bank_pkg::R_BUS_CONFIG;
         next_q.bus_config[sfr_bank_pkg::B_BUS_WIDTH] = q.bus_width_sync[1];
         next_q.compat_status = i_vector_status
                                & sfr_bank_pkg::COMPAT_KEEP_MASK;
         for (int p = 0; p < sfr_bank_pkg::NUM_PORTS; p++) begin
            if (q.ext_code_sync[1] && sfr_bank_pkg::EXT_BUS_PORTS[p]) begin
               next_q.cfg_a[p] = sfr_bank_pkg::R_CONFIG_A_PUSH;
               next_q.cfg_b[p] = sfr_bank_pkg::R_CONFIG_B_PUSH;
            end else begin
               next_q.cfg_a[p] = sfr_bank_pkg::R_CONFIG_A_QUASI;
               next_q.cfg_b[p] = sfr_bank_pkg::R_CONFIG_B_QUASI;
            end
         end
      end
   end

   always_ff @(posedge i_sys_clk or posedge i_reset) begin
      if (i_reset) begin
         q <= '0;
      end else begin
         q <= next_q;
      end
   end

   assign o_rdata = q.rdata;
   assign o_rd_valid = q.rd_valid;
   assign o_init_done = q.init_done;
   assign o_timer01_control = t01_ctl_q;
   assign o_timer01_toggle_status = q.timer01_toggle;
   assign o_timer2_control = t2_ctl_q;
   assign o_timer2_mode = q.timer2_mode;
   assign o_timer01_mode = q.timer01_mode;
   assign o_watchdog_control = wd_ctl_q;
   assign o_watchdog_reload = q.watchdog_reload;
   assign o_watchdog_feed_first = q.feed_first;
   assign o_watchdog_feed_second = q.feed_second;
   assign o_segment_select = q.segment_select;
   assign o_soft_irq_request = q.soft_irq_request;
   assign o_soft_irq_enable = q.soft_irq_enable;
   assign o_system_config = q.system_config;
   assign o_uart1_addr_mask = q.uart1_addr_mask;
   assign o_reset_cause = q.reset_cause;
   assign o_bus_config = q.bus_config;
   assign o_compat_status = q.compat_status;
   assign o_port_config_a = q.cfg_a;
   assign o_port_config_b = q.cfg_b;

   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (i_reset);

   a_wide_write_low: assert property (
      (i_wr_en && i_wide && i_addr == sfr_bank_pkg::A_SEGMENT_SELECT)
      |=> o_segment_select == $past(i_wdata[7:0]))
      else $error("wide write did not store the low byte");
   a_read_low_byte: assert property (
      (i_rd_en && !i_wr_en && i_addr == sfr_bank_pkg::A_SOFT_IRQ_ENABLE)
      |=> o_rd_valid && o_rdata[7:0] == o_soft_irq_enable)
      else $error("read did not return the register in the low byte");
   a_guard_keeps_flag: assert property (
      (rd_t01_ctl && !i_wr_en) ##1 (!i_rd_en && !i_wr_en)[*2]
      ##1 (i_timer0_overflow && !i_rd_en && !i_wr_en) ##1 (!i_rd_en && !i_wr_en)
      ##1 (wr_t01_ctl && !i_rd_en && !i_wdata[5])
      |=> o_timer01_control[sfr_bank_pkg::B_TIMER0_OVERFLOW])
      else $error("flag set during read-modify-write was lost");
   a_set_beats_write: assert property (
      (i_timer2_overflow && i_wr_en
       && i_addr == sfr_bank_pkg::A_TIMER2_CONTROL)
      |=> o_timer2_control[sfr_bank_pkg::B_TIMER2_OVERFLOW])
      else $error("stale write cleared a flag set in the same cycle");
   a_cause_onehot: assert property (
      q.init_done |-> $onehot(o_reset_cause))
      else $error("reset cause is not one-hot");
   a_watchdog_reset: assert property (
      $rose(q.init_done) |-> o_watchdog_control
      == (o_reset_cause[sfr_bank_pkg::B_CAUSE_WATCHDOG]
          ? sfr_bank_pkg::R_WATCHDOG_DOG : sfr_bank_pkg::R_WATCHDOG_OTHER))
      else $error("watchdog control reset value wrong");
   a_bus_config_load: assert property (
      $rose(q.init_done) |-> o_bus_config[7:3] == 5'h00
      && o_bus_config[1:0] == 2'h3)
      else $error("bus config not loaded as 00000a11");
   a_internal_quasi: assert property (
      $rose(q.init_done) |-> o_port_config_a[15:8] == sfr_bank_pkg::R_CONFIG_A_QUASI
      && o_port_config_b[15:8] == sfr_bank_pkg::R_CONFIG_B_QUASI)
      else $error("non-bus port not quasi-bidirectional after reset");
   a_compat_flags_clear: assert property (
      $rose(q.init_done) |-> (o_compat_status & ~sfr_bank_pkg::COMPAT_KEEP_MASK) == 8'h00)
      else $error("user flags or parity not cleared at reset");
   a_toggle_bits_only: assert property (
      (i_wr_en && i_addr == sfr_bank_pkg::A_TIMER01_TOGGLE)
      |=> o_timer01_toggle_status == ($past(i_wdata[7:0]) & 8'h05))
      else $error("toggle status stored unimplemented bits");

   c_guard_collision: cover property (
      i_timer0_overflow && wr_t01_ctl && !i_wdata[5]);
   c_wide_write: cover property (i_wr_en && i_wide);
   c_watchdog_cause: cover property ($rose(q.init_done) && i_cause_watchdog);
   c_feed_pair: cover property (o_watchdog_feed_first ##[1:8] o_watchdog_feed_second);
endmodule
`default_nettype wire

// File: testbench/core_bus_model.sv
`timescale 1ns/10ps
`default_nettype none
module core_bus_model (
   input wire logic i_sys_clk,
   input wire logic [15:0] i_rdata,
   output logic [10:0] o_addr,
   output logic o_rd_en,
   output logic o_wr_en,
   output logic o_wide,
   output logic [15:0] o_wdata
);
   initial begin
      o_addr = 11'h000;
      o_rd_en = 1'b0;
      o_wr_en = 1'b0;
      o_wide = 1'b0;
      o_wdata = 16'h0000;
   end
   // upper byte carries real data so a leak into the register shows
   task automatic wr(input logic [10:0] a, input logic [15:0] d, input logic w);
      @(negedge i_sys_clk);
      o_addr = a;
      o_wdata = d;
      o_wide = w;
      o_wr_en = 1'b1;
      @(negedge i_sys_clk);
      o_wr_en = 1'b0;
      o_wdata = ~d;
      o_addr = ~a;
   endtask
   task automatic rd(input logic [10:0] a, input logic w, output logic [7:0] q);
      @(negedge i_sys_clk);
      o_addr = a;
      o_wide = w;
      o_rd_en = 1'b1;
      @(negedge i_sys_clk);
      o_rd_en = 1'b0;
      o_addr = ~a;
      @(negedge i_sys_clk);
      q = i_rdata[7:0];
   endtask
endmodule
`default_nettype wire

// File: testbench/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
   logic i_sys_clk = 1'b0;
   logic i_reset = 1'b1;
   logic [2:0] cause = 3'h4;
   logic [7:0] vec = 8'hFF;
   logic bw = 1'b1;
   logic ecs = 1'b0;
   logic [6:0] fl = 7'h00;
   logic [10:0] i_addr;
   logic i_rd_en, i_wr_en, i_wide, o_rd_valid;
   logic [15:0] i_wdata, o_rdata;
   logic [7:0] t01c, t2c, wdc, bcfg, cst, q;
   logic [2:0] rc;
   logic [55:0] pca, pcb;
   int errors = 0;
   int tests_run = 0;
   int cyc = 0;
   always #12.5 i_sys_clk = ~i_sys_clk;
   core_bus_model core (.i_sys_clk, .i_rdata(o_rdata), .o_addr(i_addr), .o_rd_en(i_rd_en),
      .o_wr_en(i_wr_en), .o_wide(i_wide), .o_wdata(i_wdata));
   sfr_bus_register_bank dut (.i_sys_clk, .i_reset, .i_addr, .i_rd_en, .i_wr_en, .i_wide,
      .i_wdata, .i_cause_watchdog(cause[2]), .i_cause_command(cause[1]),
      .i_cause_external_pin(cause[0]), .i_vector_status(vec), .i_bus_width_pin(bw),
      .i_external_code_select_pin(ecs), .i_timer1_overflow(fl[6]), .i_timer0_overflow(fl[5]),
      .i_ext1_flag(fl[4]), .i_ext0_flag(fl[3]), .i_timer2_overflow(fl[2]),
      .i_timer2_external_flag(fl[1]), .i_watchdog_timeout_flag(fl[0]), .o_rdata, .o_rd_valid,
      .o_init_done(), .o_timer01_control(t01c), .o_timer01_toggle_status(),
      .o_timer2_control(t2c), .o_timer2_mode(), .o_timer01_mode(), .o_watchdog_control(wdc),
      .o_watchdog_reload(), .o_watchdog_feed_first(), .o_watchdog_feed_second(),
      .o_segment_select(), .o_soft_irq_request(), .o_soft_irq_enable(), .o_system_config(),
      .o_uart1_addr_mask(), .o_reset_cause(rc), .o_bus_config(bcfg), .o_compat_status(cst),
      .o_port_config_a(pca), .o_port_config_b(pcb));
   task automatic summarize();
      $display("errors=%0d tests_run=%0d", errors, tests_run);
      if (errors == 0 && tests_run > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      tests_run++;
      if (got !== exp) begin
         errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // cause and straps must be steady before release, loads happen edges later
   task automatic do_reset(input logic [2:0] c, input logic e, input logic b);
      @(negedge i_sys_clk);
      i_reset = 1'b1;
      cause = c;
      ecs = e;
      bw = b;
      repeat (16) @(negedge i_sys_clk);
      i_reset = 1'b0;
      repeat (5) @(negedge i_sys_clk);
   endtask
   task automatic pulse(input logic [6:0] m);
      @(negedge i_sys_clk);
      fl = m;
      @(negedge i_sys_clk);
      fl = 7'h00;
   endtask
   task automatic t_dog_reset();
      chk(wdc, 8'hE6);
      chk(rc, 3'h4);
      chk(bcfg, {5'h00, bw, 2'h3});
      chk(cst, vec & ~8'h23);
      chk(t2c, 8'h00);
      chk({pca[7:0], pcb[7:0]}, 16'hFF00);
      core.rd(11'h4F2, 1'b0, q);
      chk(q, 8'h00);
   endtask
   task automatic t_pin_reset();
      do_reset(3'h1, 1'b1, 1'b0);
      chk(wdc, 8'hE4);
      chk(rc, 3'h1);
      chk(bcfg, 8'h03);
      chk(pcb[7:0], 8'hFF);
      chk(pcb[15:8], 8'h00);
   endtask
   task automatic t_fields();
      core.wr(11'h403, 16'hA55A, 1'b1);
      core.rd(11'h403, 1'b1, q);
      chk(q, 8'h5A);
      core.wr(11'h411, 16'h00FF, 1'b0);
      core.rd(11'h411, 1'b0, q);
      chk(q, 8'h05);
      core.wr(11'h419, 16'h00FF, 1'b0);
      core.rd(11'h419, 1'b0, q);
      chk(q, 8'h33);
      core.wr(11'h45C, 16'h00A5, 1'b0);
      core.rd(11'h45C, 1'b0, q);
      chk(q, 8'hA5);
      core.wr(11'h47A, 16'h00FF, 1'b0);
      core.rd(11'h47A, 1'b1, q);
      chk(q, 8'h7F);
   endtask
   task automatic t_guard();
      core.rd(11'h410, 1'b0, q);
      pulse(7'h20);
      core.wr(11'h410, 16'h0000, 1'b0);
      chk(t01c, 8'h20);
      core.wr(11'h410, 16'h0000, 1'b0);
      chk(t01c, 8'h00);
      pulse(7'h48);
      chk(t01c, 8'h82);
      core.rd(11'h41F, 1'b0, q);
      pulse(7'h01);
      core.wr(11'h41F, 16'h00E4, 1'b0);
      chk(wdc, 8'hE6);
      fork
         core.wr(11'h418, 16'h0000, 1'b0);
         pulse(7'h04);
      join
      @(negedge i_sys_clk);
      chk(t2c, 8'h80);
   endtask
   always @(posedge i_sys_clk) begin
      cyc++;
      if (cyc == 3000) begin
         errors++;
         summarize();
      end
   end
   initial begin
      do_reset(3'h4, 1'b0, 1'b1);
      t_dog_reset();
      t_fields();
      t_guard();
      t_pin_reset();
      summarize();
   end
endmodule
`default_nettype wire
